/* File: design/tmc_consts.svh */
// timing, register map and reset constants for the transceiver mode controller
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
`define TMC_CLK_NS          20
`define TMC_T_STARTUP_NS    10000
`define TMC_T_MODE_NS       16000
`define TMC_T_MODE_LW_NS    16000
`define TMC_T_MODE_RW_NS    22000
`define TMC_T_HOLD_NS       10000
`define TMC_T_WAKE_EN_NS    70000
`define TMC_T_WAKE_FILT_NS  21000
`define TMC_T_LFLG_NS       6000
`define TMC_T_RFLG_NS       11000
`define TMC_T_WUP_FILT_NS   1000
`define TMC_WAKE_PATTERN_TIMEOUT_MS     2
`define TMC_T_TXDIS_NS      700
`define TMC_T_TXREC_NS      25000
`define TMC_T_UVD_MS        160
`define TMC_T_UVR_US        600
`define TMC_A_CTRL          8'h00
`define TMC_A_STATUS        8'h04
`define TMC_A_IRQ_STAT      8'h08
`define TMC_A_IRQ_MASK      8'h0c
`define TMC_CTRL_FLAG_CLR   0
`define TMC_MASK_RST        5'h00
`define TMC_RESP_OKAY       2'h0
`define TMC_RESP_SLVERR     2'h2
`endif

/* File: design/tmc_pkg.sv */
// types shared by the transceiver mode controller
package tmc_pkg;
    typedef enum logic [2:0] {
        TMC_OFF     = 3'b000,
        TMC_STANDBY = 3'b001,
        TMC_NORMAL  = 3'b010,
        TMC_SILENT  = 3'b011,
        TMC_GTS     = 3'b100,
        TMC_SLEEP   = 3'b101
    } tmc_mode_t;
    typedef enum logic [1:0] {
        TMC_WP_IDLE = 2'b00,
        TMC_WP_DOM  = 2'b01,
        TMC_WP_REC  = 2'b10
    } tmc_wup_t;
endpackage

/* File: design/tmc_mode_timing_ctrl.sv */
// operating mode, wake and supply timing controller of a can transceiver
//
// Notes on behaviour
// - battery available: reach standby within 100 us
// - pin mode change completes 7 to 50 us
// - local wake mode change 10 to 38 us
// - remote wake mode change 10 to 63 us
// - go-to-sleep held: sleep after 3 to 50 us
// - wake input enabled 40-200 us after power-on
// - wake pin change accepted after 5-60 us
// - local wake sets flag after 3-13 us
// - bus pattern phases filtered 0.15-1.8 us
// - partial bus pattern dropped after 1-5 ms
// - remote wake sets flag after 3-38 us
// - supply undervoltage disables transmitter about 0.7 us
// - both supplies good: transmitter back 14-75 us
// - undervoltage flag set after 100-400 ms low
// - undervoltage flag cleared after 0.35-1.3 ms good
// - pin encoding selects normal, silent, standby, go-to-sleep
// - any undervoltage flag forces sleep mode
// - wake event in sleep moves to standby
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_mode_timing_ctrl #(
    parameter int WUP_TO_CYC = `TMC_WAKE_PATTERN_TIMEOUT_MS * 1000000 / `TMC_CLK_NS,
    parameter int UVD_CYC    = `TMC_T_UVD_MS * 1000000 / `TMC_CLK_NS,
    parameter int UVR_CYC    = `TMC_T_UVR_US * 1000 / `TMC_CLK_NS
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // host mode pins and wake sources, asynchronous
    input  wire logic              i_standby_ctl_n,
    input  wire logic              i_mode_sel,
    input  wire logic              i_wake_pin,
    input  wire logic              i_bus_dominant,
    // supply monitors, high while above threshold, asynchronous
    input  wire logic              i_vb_ok,
    input  wire logic              i_vcc_ok,
    input  wire logic              i_vio_ok,
    // transceiver controls
    output var tmc_pkg::tmc_mode_t o_mode,
    output logic                   o_tx_enable,
    output logic                   o_rx_enable,
    output logic                   o_regulator_inhibit_out,
    output logic                   o_wake_flag,
    output logic                   o_irq,
    // axi4-lite slave
    input  wire logic [7:0]        i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [7:0]        i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready
);
    import tmc_pkg::*;

    localparam logic [11:0] START_CYC  = 12'(`TMC_T_STARTUP_NS / `TMC_CLK_NS);
    localparam logic [11:0] MODE_CYC   = 12'(`TMC_T_MODE_NS / `TMC_CLK_NS);
    localparam logic [11:0] MODE_LW    = 12'(`TMC_T_MODE_LW_NS / `TMC_CLK_NS);
    localparam logic [11:0] MODE_RW    = 12'(`TMC_T_MODE_RW_NS / `TMC_CLK_NS);
    localparam logic [11:0] HOLD_CYC   = 12'(`TMC_T_HOLD_NS / `TMC_CLK_NS);
    localparam logic [11:0] WAKE_EN    = 12'(`TMC_T_WAKE_EN_NS / `TMC_CLK_NS);
    localparam logic [11:0] WAKE_FILT  = 12'(`TMC_T_WAKE_FILT_NS / `TMC_CLK_NS);
    localparam logic [11:0] LFLG_CYC   = 12'(`TMC_T_LFLG_NS / `TMC_CLK_NS);
    localparam logic [11:0] RFLG_CYC   = 12'(`TMC_T_RFLG_NS / `TMC_CLK_NS);
    localparam logic [11:0] WUP_FILT   = 12'(`TMC_T_WUP_FILT_NS / `TMC_CLK_NS);
    localparam logic [11:0] TXDIS_CYC  = 12'(`TMC_T_TXDIS_NS / `TMC_CLK_NS);
    localparam logic [11:0] TXREC_CYC  = 12'(`TMC_T_TXREC_NS / `TMC_CLK_NS);

    if (WUP_TO_CYC < 2 || UVD_CYC < 2 || UVR_CYC < 2) begin : g_chk
        $error("timeout counts must be at least two cycles");
    end

    // word-aligned register match, used by both bus channels
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // undervoltage timer terminal count for the pending flag change
    function automatic logic [31:0] uv_lim(input logic flag);
        return flag ? 32'(UVR_CYC - 1) : 32'(UVD_CYC - 1);
    endfunction

    // three-stage synchronisers; a level counts once stages two and three agree
    logic [6:0] sync1, sync2, sync3, pin_f;
    wire  [6:0] pin_raw = {i_vio_ok, i_vcc_ok, i_vb_ok, i_bus_dominant,
                           i_wake_pin, i_mode_sel, i_standby_ctl_n};
    wire  [6:0] agree      = ~(sync2 ^ sync3);
    wire  [6:0] next_pin_f = (sync2 & agree) | (pin_f & ~agree);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            sync3 <= 7'h00;
            pin_f <= 7'h00;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_f <= next_pin_f;
        end
    end

    wire standby_ctl_n_f = pin_f[0];
    wire en_f   = pin_f[1];
    wire wake_f = pin_f[2];
    wire bus_f  = pin_f[3];
    wire vb_f   = pin_f[4];
    wire [1:0] sup_ok   = pin_f[6:5];
    wire       sup_good = &sup_ok;
    // battery loss is power-off: all state but the bus registers and synchronisers starts over
    wire rst = i_reset | ~vb_f;

    // pin request decode
    tmc_mode_t req;
    assign req = !standby_ctl_n_f ? (en_f ? TMC_GTS : TMC_STANDBY)
                         : (en_f ? TMC_NORMAL : TMC_SILENT);

    logic        lwake, rwake, pend, standby_ctl_n_q, wake_en;
    logic [1:0]  uv_flag;
    logic [11:0] mode_cnt;
    tmc_mode_t   tgt, req_q, mode_q;
    wire wake_evt  = lwake | rwake;
    wire uv_any    = |uv_flag;
    wire req_chg   = req != req_q;
    wire standby_ctl_n_rise = standby_ctl_n_f & ~standby_ctl_n_q;
    wire lp_mode   = o_mode == TMC_STANDBY || o_mode == TMC_GTS || o_mode == TMC_SLEEP;

    // mode sequencer; every transition but the undervoltage drop to sleep waits out mode_cnt
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_mode   <= TMC_OFF;
            tgt      <= TMC_STANDBY;
            pend     <= 1'b0;
            mode_cnt <= START_CYC;
            req_q    <= TMC_STANDBY;
            standby_ctl_n_q   <= 1'b0;
        end else begin
            req_q  <= req;
            standby_ctl_n_q <= standby_ctl_n_f;
            if (o_mode == TMC_OFF) begin
                if (mode_cnt == 12'h000) begin
                    o_mode <= TMC_STANDBY;
                end else begin
                    mode_cnt <= mode_cnt - 12'h001;
                end
            end else if (uv_any && o_mode != TMC_SLEEP) begin
                o_mode <= TMC_SLEEP;
                pend   <= 1'b0;
            end else if (o_mode == TMC_SLEEP && wake_evt) begin
                pend     <= 1'b1;
                tgt      <= TMC_STANDBY;
                mode_cnt <= lwake ? MODE_LW : MODE_RW;
            end else if (o_mode == TMC_SLEEP && standby_ctl_n_rise && !uv_any) begin
                pend     <= 1'b1;
                tgt      <= req;
                mode_cnt <= MODE_CYC;
            end else if (o_mode != TMC_SLEEP && req_chg) begin
                pend     <= 1'b1;
                tgt      <= req;
                mode_cnt <= MODE_CYC;
            end else if (pend) begin
                if (mode_cnt == 12'h001) begin
                    o_mode   <= tgt;
                    pend     <= 1'b0;
                    mode_cnt <= HOLD_CYC;
                end else begin
                    mode_cnt <= mode_cnt - 12'h001;
                end
            end else if (o_mode == TMC_GTS) begin
                // a wake during the hold restarts it
                if (wake_evt) begin
                    mode_cnt <= HOLD_CYC;
                end else if (mode_cnt == 12'h000) begin
                    o_mode <= TMC_SLEEP;
                end else begin
                    mode_cnt <= mode_cnt - 12'h001;
                end
            end
        end
    end

    // wake input enable, counted once after power-on only
    logic [11:0] we_cnt;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            wake_en <= 1'b0;
            we_cnt  <= WAKE_EN;
        end else if (o_mode != TMC_OFF && !wake_en) begin
            wake_en <= we_cnt == 12'h001;
            we_cnt  <= we_cnt - 12'h001;
        end
    end

    // local wake filter: either edge, held for the filter time
    logic        wk_ref;
    logic [11:0] wk_cnt;
    wire wk_arm = lp_mode & wake_en;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            wk_ref <= 1'b0;
            wk_cnt <= 12'h000;
            lwake  <= 1'b0;
        end else begin
            lwake <= 1'b0;
            if (!wk_arm || wake_f == wk_ref) begin
                wk_cnt <= 12'h000;
                if (!wk_arm) wk_ref <= wake_f;
            end else if (wk_cnt == WAKE_FILT - 12'h001) begin
                wk_ref <= wake_f;
                wk_cnt <= 12'h000;
                lwake  <= 1'b1;
            end else begin
                wk_cnt <= wk_cnt + 12'h001;
            end
        end
    end

    // bus wake pattern: dominant, recessive, dominant, each phase filtered
    logic        bus_q;
    logic [11:0] bf_cnt;
    logic [31:0] to_cnt;
    tmc_wup_t    wst;
    wire bus_take = (bus_f != bus_q) && bf_cnt == WUP_FILT - 12'h001;
    wire q_rise   = bus_take & bus_f;
    wire q_fall   = bus_take & ~bus_f;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus_q  <= 1'b0;
            bf_cnt <= 12'h000;
            wst    <= TMC_WP_IDLE;
            to_cnt <= 32'h0000_0000;
            rwake  <= 1'b0;
        end else begin
            rwake <= 1'b0;
            if (bus_f == bus_q) begin
                bf_cnt <= 12'h000;
            end else if (bus_take) begin
                bus_q  <= bus_f;
                bf_cnt <= 12'h000;
            end else begin
                bf_cnt <= bf_cnt + 12'h001;
            end
            if (!lp_mode || (wst != TMC_WP_IDLE && to_cnt == 32'h0000_0000)) begin
                wst <= TMC_WP_IDLE;
            end else begin
                if (to_cnt != 32'h0000_0000) to_cnt <= to_cnt - 32'h0000_0001;
                case (wst)
                    TMC_WP_IDLE: begin
                        if (q_rise) begin
                            wst    <= TMC_WP_DOM;
                            to_cnt <= 32'(WUP_TO_CYC);
                        end
                    end
                    TMC_WP_DOM: begin
                        if (q_fall) wst <= TMC_WP_REC;
                    end
                    TMC_WP_REC: begin
                        if (q_rise) begin
                            wst   <= TMC_WP_IDLE;
                            rwake <= 1'b1;
                        end
                    end
                    default: wst <= TMC_WP_IDLE;
                endcase
            end
        end
    end

    // wake flag delay; a new set beats a software clear in the same cycle
    logic [11:0] fl_cnt;
    wire flag_clr;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            fl_cnt      <= 12'h000;
            o_wake_flag <= 1'b0;
        end else begin
            if (wake_evt) begin
                fl_cnt <= lwake ? LFLG_CYC : RFLG_CYC;
            end else if (fl_cnt != 12'h000) begin
                fl_cnt <= fl_cnt - 12'h001;
            end
            if (fl_cnt == 12'h001) begin
                o_wake_flag <= 1'b1;
            end else if (flag_clr) begin
                o_wake_flag <= 1'b0;
            end
        end
    end

    // undervoltage flags: timer runs only while supply disagrees with flag
    logic [31:0] uv_cnt [2];
    wire  [1:0]  uv_act = ~(sup_ok ^ uv_flag);
    wire  [1:0]  uv_hit = uv_act & {uv_cnt[1] == uv_lim(uv_flag[1]), uv_cnt[0] == uv_lim(uv_flag[0])};
    wire  [1:0]  uv_set = uv_hit & ~uv_flag;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            uv_flag <= 2'h0;
            uv_cnt  <= '{32'h0000_0000, 32'h0000_0000};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!uv_act[i]) begin
                    uv_cnt[i] <= 32'h0000_0000;
                end else if (uv_hit[i]) begin
                    uv_flag[i] <= ~uv_flag[i];
                    uv_cnt[i]  <= 32'h0000_0000;
                end else begin
                    uv_cnt[i] <= uv_cnt[i] + 32'h0000_0001;
                end
            end
        end
    end

    // transmitter gate follows the raw supply state, not the slow flags
    logic        tx_ok;
    logic [11:0] tg_cnt;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            tx_ok  <= 1'b0;
            tg_cnt <= 12'h000;
        end else if (tx_ok == sup_good) begin
            tg_cnt <= 12'h000;
        end else if (tg_cnt == (tx_ok ? TXDIS_CYC : TXREC_CYC) - 12'h001) begin
            tx_ok  <= sup_good;
            tg_cnt <= 12'h000;
        end else begin
            tg_cnt <= tg_cnt + 12'h001;
        end
    end

    // registered pin outputs
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_tx_enable             <= 1'b0;
            o_rx_enable             <= 1'b0;
            o_regulator_inhibit_out <= 1'b0;
            mode_q                  <= TMC_OFF;
        end else begin
            o_tx_enable             <= o_mode == TMC_NORMAL && tx_ok;
            o_rx_enable             <= o_mode == TMC_NORMAL || o_mode == TMC_SILENT;
            o_regulator_inhibit_out <= o_mode != TMC_SLEEP && o_mode != TMC_OFF;
            mode_q                  <= o_mode;
        end
    end

    // axi4-lite handshakes; address and data may arrive in either order
    logic       aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [4:0] irq_stat, irq_mask;
    wire aw_hs       = i_awvalid & o_awready;
    wire w_hs        = i_wvalid & o_wready;
    wire b_hs        = o_bvalid & i_bready;
    wire ar_hs       = i_arvalid & o_arready;
    wire do_wr       = aw_full & w_full & ~o_bvalid;
    wire next_aw     = (aw_full | aw_hs) & ~b_hs;
    wire next_w      = (w_full | w_hs) & ~b_hs;
    wire next_bvalid = do_wr | (o_bvalid & ~i_bready);
    wire next_rvalid = ar_hs | (o_rvalid & ~i_rready);
    wire wr_ctrl     = do_wr & reg_hit(aw_addr, `TMC_A_CTRL) & w_strb[0];
    wire wr_mask     = do_wr & reg_hit(aw_addr, `TMC_A_IRQ_MASK) & w_strb[0];
    wire wr_known    = reg_hit(aw_addr, `TMC_A_CTRL) | reg_hit(aw_addr, `TMC_A_STATUS)
                     | reg_hit(aw_addr, `TMC_A_IRQ_STAT) | reg_hit(aw_addr, `TMC_A_IRQ_MASK);
    assign flag_clr  = wr_ctrl & w_data[`TMC_CTRL_FLAG_CLR];
    wire rd_known    = reg_hit(i_araddr, `TMC_A_CTRL) | reg_hit(i_araddr, `TMC_A_STATUS)
                     | reg_hit(i_araddr, `TMC_A_IRQ_STAT) | reg_hit(i_araddr, `TMC_A_IRQ_MASK);
    wire [7:0]  status_bits = {wake_en, tx_ok, uv_flag, o_wake_flag, o_mode};
    wire [31:0] rd_mux =
        reg_hit(i_araddr, `TMC_A_STATUS)   ? {24'h00_0000, status_bits} :
        reg_hit(i_araddr, `TMC_A_IRQ_STAT) ? {27'h000_0000, irq_stat} :
        reg_hit(i_araddr, `TMC_A_IRQ_MASK) ? {27'h000_0000, irq_mask} : 32'h0000_0000;
    // status clears on read, but an event in the same cycle still lands
    wire        irq_rc   = ar_hs & reg_hit(i_araddr, `TMC_A_IRQ_STAT);
    wire [4:0]  irq_evt  = {o_mode != mode_q, uv_set, rwake, lwake};
    wire [4:0]  next_irq = irq_evt | (irq_stat & ~{5{irq_rc}});
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `TMC_RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rresp   <= `TMC_RESP_OKAY;
            o_rdata   <= 32'h0000_0000;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            irq_stat  <= 5'h00;
            irq_mask  <= `TMC_MASK_RST;
            o_irq     <= 1'b0;
        end else begin
            aw_full   <= next_aw;
            w_full    <= next_w;
            o_awready <= ~next_aw;
            o_wready  <= ~next_w;
            o_bvalid  <= next_bvalid;
            o_arready <= ~next_rvalid;
            o_rvalid  <= next_rvalid;
            if (aw_hs) aw_addr <= i_awaddr;
            if (w_hs) begin
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (do_wr) o_bresp <= wr_known ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
            if (ar_hs) begin
                o_rdata <= rd_mux;
                o_rresp <= rd_known ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
            end
            if (wr_mask) irq_mask <= w_data[4:0];
            irq_stat <= next_irq;
            o_irq    <= |(next_irq & (wr_mask ? w_data[4:0] : irq_mask));
        end
    end

    // checks on the timing sequencer
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (rst);
    localparam int A_START = int'(START_CYC) + 2;
    localparam int A_LFLG  = int'(LFLG_CYC);

    property p_startup;
        (o_mode == TMC_OFF) |-> ##[1:A_START] (o_mode == TMC_STANDBY);
    endproperty
    a_startup: assert property (p_startup) else $error("startup to standby too slow");
    property p_mode_req;
        (req_chg && lp_mode && o_mode != TMC_SLEEP && !uv_any)
            |=> (pend && mode_cnt == MODE_CYC && tgt == $past(req));
    endproperty
    a_mode_req: assert property (p_mode_req) else $error("pin request not timed");
    property p_mode_land;
        (pend && mode_cnt == 12'h001 && !uv_any && !req_chg && o_mode != TMC_SLEEP)
            |=> (o_mode == $past(tgt) && !pend);
    endproperty
    a_mode_land: assert property (p_mode_land) else $error("mode did not land");
    property p_gts;
        (o_mode == TMC_GTS && !pend && mode_cnt == 12'h000 && !uv_any && !req_chg && !wake_evt)
            |=> (o_mode == TMC_SLEEP);
    endproperty
    a_gts: assert property (p_gts) else $error("go-to-sleep hold did not end in sleep");
    property p_wake_en;
        (!wake_en && we_cnt == 12'h001 && o_mode != TMC_OFF) |=> wake_en;
    endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake input not enabled");
    property p_lwake;
        lwake |-> ($past(wk_cnt) == WAKE_FILT - 12'h001 && $past(wk_arm));
    endproperty
    a_lwake: assert property (p_lwake) else $error("local wake without full filter");
    property p_lflag;
        lwake |=> (fl_cnt == LFLG_CYC) ##A_LFLG o_wake_flag;
    endproperty
    a_lflag: assert property (p_lflag) else $error("local wake flag delay wrong");
    property p_rflag;
        (rwake && !lwake) |=> (fl_cnt == RFLG_CYC);
    endproperty
    a_rflag: assert property (p_rflag) else $error("remote wake flag delay wrong");
    property p_wup_to;
        (wst != TMC_WP_IDLE && to_cnt == 32'h0000_0000) |=> (wst == TMC_WP_IDLE && !rwake);
    endproperty
    a_wup_to: assert property (p_wup_to) else $error("pattern timeout ignored");
    property p_txdis;
        (tx_ok && !sup_good && tg_cnt == TXDIS_CYC - 12'h001) |=> !tx_ok ##1 !o_tx_enable;
    endproperty
    a_txdis: assert property (p_txdis) else $error("transmitter not disabled");
    property p_uvd;
        $rose(uv_flag[0]) |-> $past(uv_cnt[0]) == 32'(UVD_CYC - 1);
    endproperty
    a_uvd: assert property (p_uvd) else $error("undervoltage flag set early");
    property p_uv_force;
        (uv_any && o_mode != TMC_OFF && o_mode != TMC_SLEEP) |=> (o_mode == TMC_SLEEP);
    endproperty
    a_uv_force: assert property (p_uv_force) else $error("undervoltage did not force sleep");
    property p_sleep_wake;
        (o_mode == TMC_SLEEP && wake_evt) |=> (pend && tgt == TMC_STANDBY);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("wake in sleep not taken");

    c_normal: cover property (o_mode == TMC_NORMAL && o_tx_enable);
    c_sleep:  cover property ($past(o_mode) == TMC_GTS && o_mode == TMC_SLEEP);
    c_rwake:  cover property (rwake && o_mode == TMC_SLEEP);
    c_uv:     cover property ($rose(uv_flag[1]));
endmodule
`default_nettype wire

/* File: testbench/tmc_host_model.sv */
// host controller model driving the two mode pins
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
    // clock and requested pin pair {standby_ctl_n, mode_sel}
    input  wire logic       i_clk,
    input  wire logic [1:0] i_req,
    // mode pins
    output logic            o_standby_ctl_n,
    output logic            o_mode_sel
);
    // pins move only after an edge and then stand, so a go-to-sleep request is held
    always @(posedge i_clk) begin
        {o_standby_ctl_n, o_mode_sel} <= i_req;
    end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tmc_pkg::*;
    logic i_clk = 0, i_reset = 1, i_wake_pin = 0, i_bus_dominant = 0, i_vb_ok = 1, i_vcc_ok = 1, i_vio_ok = 1;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic [7:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, o_rdata, seed = 32'h63;
    logic [3:0] i_wstrb = 4'hf;
    logic [1:0] req = 2'h0, o_rresp;
    wire logic i_standby_ctl_n, i_mode_sel;
    wire logic [2:0] po;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [41:0] q[$];
    logic [33:0] mq[$];
    int errors = 0, checks = 0;
    logic [1:0] pins[4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    tmc_mode_t md[4] = '{TMC_NORMAL, TMC_SILENT, TMC_STANDBY, TMC_GTS};
    tmc_mode_t prev = TMC_STANDBY;
    tmc_host_model host (.i_clk, .i_req(req), .o_standby_ctl_n(i_standby_ctl_n), .o_mode_sel(i_mode_sel));
    // small counts keep the undervoltage timers short
    tmc_mode_timing_ctrl #(.WUP_TO_CYC(200), .UVD_CYC(300), .UVR_CYC(100)) DUT (
        .i_clk, .i_reset, .i_standby_ctl_n, .i_mode_sel, .i_wake_pin, .i_bus_dominant, .i_vb_ok, .i_vcc_ok,
        .i_vio_ok, .o_mode(), .o_tx_enable(po[2]), .o_rx_enable(po[1]),
        .o_regulator_inhibit_out(po[0]), .o_wake_flag(), .o_irq,
        .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp(), .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
    always #10 i_clk = ~i_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic conclude();
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // readies are looked at mid-cycle, where they equal what the next edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw, w, b;
        n = 0;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while ((i_awvalid | i_wvalid | i_bready | n == 0) && n < 99) begin
            @(negedge i_clk);
            aw = o_awready;
            w = o_wready;
            b = o_bvalid;
            @(posedge i_clk);
            if (aw) i_awvalid <= 1'b0;
            if (w) i_wvalid <= 1'b0;
            if (b) i_bready <= 1'b0;
            n++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
        int n;
        logic ar, r;
        n = 0;
        q.push_back({a, e});
        mq.push_back(m);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while ((i_arvalid | i_rready | n == 0) && n < 99) begin
            @(negedge i_clk);
            ar = o_arready;
            r = o_rvalid;
            @(posedge i_clk);
            if (ar) i_arvalid <= 1'b0;
            if (r) i_rready <= 1'b0;
            n++;
        end
    endtask
    // each read answer is compared with the oldest expectation
    always @(negedge i_clk) begin
        if (o_rvalid && i_rready && q.size() > 0) begin
            checks++;
            if ((({o_rresp, o_rdata} ^ q[0][33:0]) & mq[0]) !== 34'h0) begin
                errors++;
                $display("MISMATCH read %h exp %h got %h", q[0][41:34], q[0][33:0], {o_rresp, o_rdata});
            end
            void'(q.pop_front());
            void'(mq.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (600) @(posedge i_clk);
        rd(8'h04, {31'h0, TMC_STANDBY}, 34'h7);
        rd(8'h10, 34'h2_0000_0000, 34'h3_ffff_ffff);
        seed = xs(seed);
        wr(8'h0c, seed);
        rd(8'h0c, {29'h0, seed[4:0]}, 34'h3_ffff_ffff);
        wr(8'h0c, 32'h1);
        for (int i = 0; i < 4; i++) begin
            req <= pins[i];
            repeat (400) @(posedge i_clk);
            rd(8'h04, {31'h0, prev}, 34'h7);
            repeat (450) @(posedge i_clk);
            rd(8'h04, {31'h0, md[i]}, 34'h7);
            prev = md[i];
        end
        repeat (520) @(posedge i_clk);
        rd(8'h04, {31'h0, TMC_SLEEP}, 34'h7);
        i_wake_pin <= 1'b1;
        repeat (100) @(posedge i_clk);
        i_wake_pin <= 1'b0;
        repeat (1300) @(posedge i_clk);
        rd(8'h04, {31'h0, TMC_SLEEP}, 34'h7);
        i_wake_pin <= 1'b1;
        repeat (1200) @(posedge i_clk);
        @(negedge i_clk);
        checks++;
        if (o_irq !== 1'b1) begin
            errors++;
            $display("MISMATCH o_irq exp 1 got %b", o_irq);
        end
        rd(8'h08, 34'h1, 34'h1);
        repeat (700) @(posedge i_clk);
        rd(8'h04, 34'h9, 34'hf);
        wr(8'h00, 32'h1);
        rd(8'h04, 34'h0, 34'h8);
        req <= 2'h3;
        repeat (900) @(posedge i_clk);
        rd(8'h04, {27'h0, 4'h8, TMC_NORMAL}, 34'h47);
        checks++;
        if (po !== 3'h7) begin
            errors++;
            $display("MISMATCH pins exp 7 got %b", po);
        end
        i_vcc_ok <= 1'b0;
        repeat (45) @(posedge i_clk);
        rd(8'h04, 34'h0, 34'h40);
        repeat (320) @(posedge i_clk);
        rd(8'h04, 34'h15, 34'h17);
        i_vcc_ok <= 1'b1;
        repeat (1300) @(posedge i_clk);
        rd(8'h04, 34'h40, 34'h50);
        i_bus_dominant <= 1'b1;
        repeat (60) @(posedge i_clk);
        i_bus_dominant <= 1'b0;
        repeat (300) @(posedge i_clk);
        i_bus_dominant <= 1'b1;
        repeat (60) @(posedge i_clk);
        rd(8'h08, 34'h0, 34'h2);
        i_bus_dominant <= 1'b0;
        repeat (60) @(posedge i_clk);
        i_bus_dominant <= 1'b1;
        repeat (1200) @(posedge i_clk);
        rd(8'h04, 34'h9, 34'hf);
        repeat (2) @(posedge i_clk);
        conclude();
    end
endmodule
`default_nettype wire
